// File: hw/llb_cfg.svh
// Encoding constants, field positions and reset values for the literal, logic and bank instruction decoder.
`ifndef LLB_CFG_SVH
`define LLB_CFG_SVH
`define LLB_OP_LOAD_LIT_ACC 8'hb0
`define LLB_OP_XOR_LIT 8'hb4
`define LLB_OP_FAR_JUMP 8'hb7
`define LLB_OP7_BANK_NIB 7'h5d
`define LLB_OP7_XOR_FILE 7'h06
`define LLB_OP7_OR_FILE 7'h04
`define LLB_OP7_ZERO_FILE 7'h14
`define LLB_DEST_BIT 8
`define LLB_ACC_RESET 8'h00
`define LLB_BANK_RESET 8'h00
`define LLB_LATCH_RESET 8'h00
`define LLB_PC_RESET 16'h0000
`endif

// File: hw/llb_pkg.sv
// Types shared by the decoder modules.
package llb_pkg;
    typedef enum logic [2:0] {
        LLB_ST_RUN = 3'h1,
        LLB_ST_FNOP = 3'h2,
        LLB_ST_IDLE = 3'h4
    } llb_state_t;
    typedef struct packed {
        logic [7:0] result;
        logic zero;
    } llb_alu_out_t;
endpackage

// File: hw/llb_alu_if.sv
// Interface carrying operands and results between the decoder and its logic unit.
`timescale 1ns/1ps
interface llb_alu_if;
    logic [7:0] a;
    logic [7:0] b;
    logic [1:0] op;
    llb_pkg::llb_alu_out_t res;
    modport ctrl (output a, output b, output op, input res);
    modport unit (input a, input b, input op, output res);
endinterface

// File: hw/llb_alu.sv
// Combinational logic unit: exclusive-OR, inclusive-OR, pass and clear with zero detect.
`timescale 1ns/1ps
module llb_alu (
    llb_alu_if.unit alu
);
    // Op 0 pass b, 1 xor, 2 or, 3 clear; zero flag follows the result.
    always_comb begin
        case (alu.op)
            2'h0: alu.res.result = alu.b;
            2'h1: alu.res.result = alu.a ^ alu.b;
            2'h2: alu.res.result = alu.a | alu.b;
            default: alu.res.result = 8'h00;
        endcase
        alu.res.zero = (alu.res.result == 8'h00);
    end
endmodule // llb_alu

// File: hw/llb_decoder.sv
// Decoder and execute stage for literal, logic, bank and far call instructions.
// Summary of operation
// - Bank nibble load writes 4-bit literal into upper bank select bits.
// - Bank nibble load keeps lower bank select nibble unchanged.
// - Literal load puts 8-bit literal into accumulator; flags untouched.
// - Literal xor updates accumulator and zero flag.
// - File xor writes accumulator or file per destination bit; updates zero.
// - Zero-file clears file; scope bit 0 also clears accumulator.
`timescale 1ns/1ps
`include "llb_cfg.svh"
module llb_decoder (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] pc_upper_latch_i,
    output logic [7:0] working_accumulator_o,
    output logic [7:0] bank_select_reg_o,
    output logic zero_flag_o,
    output logic [15:0] pc_o,
    output logic file_we_o,
    output logic [7:0] file_addr_o,
    output logic [7:0] file_wdata_o,
    output logic stack_push_o,
    output logic [15:0] stack_top_entry_o,
    output logic busy_o
);
    typedef struct packed {
        llb_pkg::llb_state_t st;
        logic [7:0] acc;
        logic [7:0] bank;
        logic zf;
        logic [15:0] pc;
        logic fwe;
        logic [7:0] faddr;
        logic [7:0] fdata;
        logic push;
        logic [15:0] ret_addr;
        logic busy;
    } llb_state_reg_t;

    llb_state_reg_t state_reg;
    llb_state_reg_t state_next;
    llb_alu_if alu_bus ();

    logic [7:0] opc;
    logic [6:0] opc7;
    logic [7:0] lit;
    logic dest;
    logic [15:0] pc_inc;

    assign opc = instr_i[15:8];
    assign opc7 = instr_i[15:9];
    assign lit = instr_i[7:0];
    assign dest = instr_i[`LLB_DEST_BIT];
    assign pc_inc = state_reg.pc + 16'h0001;

    llb_alu u_alu (.alu(alu_bus));

    // Operand steering; the literal xor feeds b from the instruction, file forms from the read port.
    always_comb begin
        alu_bus.a = state_reg.acc;
        alu_bus.b = file_rdata_i;
        alu_bus.op = 2'h0;
        if (opc == `LLB_OP_XOR_LIT) begin
            alu_bus.b = lit;
            alu_bus.op = 2'h1;
        end else if (opc7 == `LLB_OP7_XOR_FILE) begin
            alu_bus.op = 2'h1;
        end else if (opc7 == `LLB_OP7_OR_FILE) begin
            alu_bus.op = 2'h2;
        end else if (opc7 == `LLB_OP7_ZERO_FILE) begin
            alu_bus.op = 2'h3;
        end
    end

    // Next-state decode; an instruction retires in one cycle except the far call.
    always_comb begin
        state_next = state_reg;
        state_next.fwe = 1'b0;
        state_next.push = 1'b0;
        case (state_reg.st)
            llb_pkg::LLB_ST_IDLE: begin
                state_next.st = llb_pkg::LLB_ST_RUN;
            end
            llb_pkg::LLB_ST_RUN: begin
                if (instr_valid_i) begin
                    state_next.pc = pc_inc;
                    state_next.faddr = lit;
                    if (opc7 == `LLB_OP7_BANK_NIB) begin
                        // The low instruction nibble is ignored, so sloppy encodings still work.
                        state_next.bank = {instr_i[7:4], state_reg.bank[3:0]};
                    end else if (opc == `LLB_OP_LOAD_LIT_ACC) begin
                        state_next.acc = lit;
                    end else if (opc == `LLB_OP_XOR_LIT) begin
                        state_next.acc = alu_bus.res.result;
                        state_next.zf = alu_bus.res.zero;
                    end else if (opc7 == `LLB_OP7_XOR_FILE || opc7 == `LLB_OP7_OR_FILE) begin
                        state_next.zf = alu_bus.res.zero;
                        if (dest) begin
                            state_next.fwe = 1'b1;
                            state_next.fdata = alu_bus.res.result;
                        end else begin
                            state_next.acc = alu_bus.res.result;
                        end
                    end else if (opc7 == `LLB_OP7_ZERO_FILE) begin
                        state_next.fwe = 1'b1;
                        state_next.fdata = 8'h00;
                        if (!dest) begin
                            state_next.acc = 8'h00;
                        end
                    end else if (opc == `LLB_OP_FAR_JUMP) begin
                        state_next.push = 1'b1;
                        state_next.ret_addr = pc_inc;
                        state_next.pc = {pc_upper_latch_i, lit};
                        state_next.st = llb_pkg::LLB_ST_FNOP;
                    end
                end
            end
            llb_pkg::LLB_ST_FNOP: begin
                // Fetched word is discarded during the forced no-op.
                state_next.st = llb_pkg::LLB_ST_RUN;
            end
            default: begin
                state_next.st = llb_pkg::LLB_ST_IDLE;
            end
        endcase
        // Busy is kept as its own flop so the port never carries decode glitches.
        state_next.busy = (state_next.st != llb_pkg::LLB_ST_RUN);
    end

    // Single state register; synchronous reset.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg.st <= llb_pkg::LLB_ST_IDLE;
            state_reg.acc <= `LLB_ACC_RESET;
            state_reg.bank <= `LLB_BANK_RESET;
            state_reg.zf <= 1'b0;
            state_reg.pc <= `LLB_PC_RESET;
            state_reg.fwe <= 1'b0;
            state_reg.faddr <= 8'h00;
            state_reg.fdata <= 8'h00;
            state_reg.push <= 1'b0;
            state_reg.ret_addr <= 16'h0000;
            state_reg.busy <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign working_accumulator_o = state_reg.acc;
    assign bank_select_reg_o = state_reg.bank;
    assign zero_flag_o = state_reg.zf;
    assign pc_o = state_reg.pc;
    assign file_we_o = state_reg.fwe;
    assign file_addr_o = state_reg.faddr;
    assign file_wdata_o = state_reg.fdata;
    assign stack_push_o = state_reg.push;
    assign stack_top_entry_o = state_reg.ret_addr;
    assign busy_o = state_reg.busy;

    wire run_take = instr_valid_i && state_reg.st == llb_pkg::LLB_ST_RUN;

    // Bank nibble load: only the upper half moves; the accumulator and zero flag are not touched.
    a_bank_high: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_BANK_NIB |=> bank_select_reg_o[7:4] == $past(instr_i[7:4]))
        else $error("bank upper nibble not loaded");
    a_bank_low: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_BANK_NIB |=> $stable(bank_select_reg_o[3:0]))
        else $error("bank lower nibble changed");
    a_bank_no_acc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_BANK_NIB |=> $stable(working_accumulator_o) && $stable(zero_flag_o))
        else $error("bank load disturbed accumulator or flag");
    // Literal forms: the load keeps the flag, the xor recomputes it from the new accumulator.
    a_lit_load: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc == `LLB_OP_LOAD_LIT_ACC |=> working_accumulator_o == $past(lit) && $stable(zero_flag_o))
        else $error("literal load wrong");
    a_xor_lit: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc == `LLB_OP_XOR_LIT |=> working_accumulator_o == ($past(state_reg.acc) ^ $past(lit))
        && zero_flag_o == (working_accumulator_o == 8'h00))
        else $error("xor literal wrong");
    // File xor: the destination bit steers the result, the other target must hold; zero-file always writes the file.
    a_xor_file: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_XOR_FILE && dest |=> file_we_o
        && file_wdata_o == ($past(state_reg.acc) ^ $past(file_rdata_i)) && $stable(working_accumulator_o))
        else $error("xor file destination wrong");
    a_xor_to_acc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_XOR_FILE && !dest |=> !file_we_o
        && working_accumulator_o == ($past(state_reg.acc) ^ $past(file_rdata_i))
        && zero_flag_o == (working_accumulator_o == 8'h00))
        else $error("xor file accumulator destination wrong");
    a_zero_file: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_ZERO_FILE |=> file_we_o && file_wdata_o == 8'h00
        && (working_accumulator_o == 8'h00 || $past(dest)))
        else $error("zero file wrong");
    a_zero_no_flag: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_ZERO_FILE |=> $stable(zero_flag_o))
        else $error("zero file changed the flag");
    // Far call: push and jump in the first cycle, then one dead cycle before the next word.
    a_far_call: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc == `LLB_OP_FAR_JUMP |=> stack_push_o && busy_o
        && pc_o == {$past(pc_upper_latch_i), $past(lit)} ##1 !busy_o && !stack_push_o)
        else $error("far call sequence wrong");
    a_far_return: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc == `LLB_OP_FAR_JUMP |=> stack_top_entry_o == $past(pc_o) + 16'h0001)
        else $error("far call return address wrong");
    a_fnop_hold: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_reg.st == llb_pkg::LLB_ST_FNOP |=> $stable(working_accumulator_o) && !file_we_o)
        else $error("forced no-op altered state");
    a_fnop_pc: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        state_reg.st == llb_pkg::LLB_ST_FNOP |=> $stable(pc_o) && !stack_push_o && $stable(bank_select_reg_o))
        else $error("forced no-op moved program counter or bank");
    c_far_call: cover property (@(posedge clock_i) disable iff (!rst_n_i) run_take && opc == `LLB_OP_FAR_JUMP);
    c_xor_zero: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc == `LLB_OP_XOR_LIT ##1 zero_flag_o);
    c_xor_file_acc: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_XOR_FILE && !dest);
    c_bank_load: cover property (@(posedge clock_i) disable iff (!rst_n_i) run_take && opc7 == `LLB_OP7_BANK_NIB);
    c_zero_file_keep: cover property (@(posedge clock_i) disable iff (!rst_n_i)
        run_take && opc7 == `LLB_OP7_ZERO_FILE && dest);
endmodule // llb_decoder

// File: bench/tb_llb_decoder.sv
// Self-checking testbench for the literal, logic and bank instruction decoder.
`timescale 1ns/1ps
module tb_llb_decoder;
    logic clock_i, rst_n_i, instr_valid_i, zf, fwe, push, busy;
    logic [15:0] instr_i, pc, ret_addr, pc_exp;
    logic [7:0] file_rdata_i, pc_upper_latch_i, acc, bank, faddr, fdata;
    int error_cnt = 0;
    int samples_checked = 0;
    int cycles = 0;
    llb_decoder dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
        .file_rdata_i(file_rdata_i), .pc_upper_latch_i(pc_upper_latch_i), .working_accumulator_o(acc),
        .bank_select_reg_o(bank), .zero_flag_o(zf), .pc_o(pc), .file_we_o(fwe), .file_addr_o(faddr),
        .file_wdata_o(fdata), .stack_push_o(push), .stack_top_entry_o(ret_addr), .busy_o(busy));
    // Free-running 200 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    // The tests need well under a hundred cycles, so this ceiling only trips on a hang.
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            error_cnt++;
            complete_run();
        end
    end
    // Compare one observed value against its expectation.
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Present one word for a single edge; the answer is settled one step after that edge.
    task automatic exec(input logic [15:0] word, input logic [7:0] fd);
        @(posedge clock_i);
        #1;
        instr_valid_i = 1'b1;
        instr_i = word;
        file_rdata_i = fd;
        @(posedge clock_i);
        #1;
        instr_valid_i = 1'b0;
        pc_exp = pc_exp + 16'h0001;
    endtask
    // Print the counts and the verdict, then stop.
    task automatic complete_run();
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence: reset, then each instruction group in turn.
    initial begin
        rst_n_i = 1'b0;
        instr_valid_i = 1'b0;
        instr_i = 16'h0000;
        file_rdata_i = 8'h00;
        pc_upper_latch_i = 8'h3c;
        pc_exp = 16'h0000;
        repeat (2) @(posedge clock_i);
        #1;
        chk("busy", busy, 1'b1);
        chk("acc", acc, 8'h00);
        chk("pc", pc, 16'h0000);
        rst_n_i = 1'b1;
        // The first edge after release leaves the idle state, so the core is ready right after it.
        @(posedge clock_i);
        #1;
        chk("busy", busy, 1'b0);
        $display("reset test done");
        exec(16'hb0b5, 8'h00);
        chk("acc", acc, 8'hb5);
        exec(16'hb4af, 8'h00);
        chk("acc", acc, 8'h1a);
        chk("zero", zf, 1'b0);
        exec(16'hb41a, 8'h00);
        chk("zero", zf, 1'b1);
        exec(16'hb05a, 8'h00);
        chk("acc", acc, 8'h5a);
        chk("zero", zf, 1'b1);
        $display("literal test done");
        exec({7'h5d, 1'b1, 4'ha, 4'h0}, 8'h00);
        chk("bank", bank, 8'ha0);
        exec({7'h5d, 1'b0, 4'h5, 4'h0}, 8'h00);
        chk("bank", bank, 8'h50);
        $display("bank test done");
        exec({7'h06, 1'b1, 8'h21}, 8'h5a);
        chk("we", fwe, 1'b1);
        chk("addr", faddr, 8'h21);
        chk("wdata", fdata, 8'h00);
        chk("zero", zf, 1'b1);
        chk("acc", acc, 8'h5a);
        exec({7'h06, 1'b0, 8'h22}, 8'h0f);
        chk("acc", acc, 8'h55);
        chk("we", fwe, 1'b0);
        chk("zero", zf, 1'b0);
        $display("xor file test done");
        exec({7'h14, 1'b1, 8'h30}, 8'h77);
        chk("we", fwe, 1'b1);
        chk("wdata", fdata, 8'h00);
        chk("acc", acc, 8'h55);
        exec({7'h14, 1'b0, 8'h31}, 8'h77);
        chk("addr", faddr, 8'h31);
        chk("acc", acc, 8'h00);
        chk("zero", zf, 1'b0);
        chk("pc", pc, pc_exp);
        $display("zero file test done");
        // Valid stays high into the forced no-op, where the second word must be dropped.
        @(posedge clock_i);
        #1;
        instr_valid_i = 1'b1;
        instr_i = 16'hb7c4;
        @(posedge clock_i);
        #1;
        instr_i = 16'hb077;
        pc_exp = pc_exp + 16'h0001;
        chk("push", push, 1'b1);
        chk("return", ret_addr, pc_exp);
        chk("pc", pc, 16'h3cc4);
        chk("busy", busy, 1'b1);
        @(posedge clock_i);
        #1;
        instr_valid_i = 1'b0;
        chk("busy", busy, 1'b0);
        chk("push", push, 1'b0);
        chk("acc", acc, 8'h00);
        chk("pc", pc, 16'h3cc4);
        pc_exp = 16'h3cc4;
        exec(16'hb011, 8'h00);
        chk("acc", acc, 8'h11);
        chk("pc", pc, pc_exp);
        $display("far call test done");
        exec({7'h04, 1'b0, 8'h40}, 8'h82);
        chk("acc", acc, 8'h93);
        chk("zero", zf, 1'b0);
        exec({7'h04, 1'b1, 8'h41}, 8'h6c);
        chk("we", fwe, 1'b1);
        chk("wdata", fdata, 8'hff);
        chk("acc", acc, 8'h93);
        $display("or file test done");
        complete_run();
    end
endmodule // tb_llb_decoder
